// *** smet_consts.vh ***
// Constants for the signaling map / E1 frame / transparent block
`ifndef SMET_CONSTS_VH
`define SMET_CONSTS_VH
// AXI4-Lite register byte offsets
`define SMET_REG_CTRL 12'h000
`define SMET_REG_SIGTX 12'h004
`define SMET_REG_SIGRX 12'h008
`define SMET_REG_STAT 12'h00C
`define SMET_REG_TS0 12'h010
// CTRL fields
`define SMET_CTRL_SIGDIS 0
`define SMET_CTRL_LCS3 3
`define SMET_CTRL_LCS4 4
`define SMET_CTRL_FMT_LO 5
`define SMET_CTRL_FMT_HI 6
`define SMET_CTRL_MODE_LO 8
`define SMET_CTRL_MODE_HI 9
`define SMET_CTRL_RAI 12
`define SMET_CTRL_RESET 32'h0000_0001
// TS0 register: international bits and spare bits 4..8
`define SMET_TS0_RESET 32'h0000_003F
// Framing modes
`define SMET_MODE_NORMAL 2'h0
`define SMET_MODE_TR1 2'h1
`define SMET_MODE_TR2 2'h2
// Frame geometry and AXI response codes
`define SMET_FRAME_BITS 256
`define SMET_FRAME_RATE_HZ 8000
`define SMET_FAS_WORD 7'h1B
`define SMET_SIG_FRAME 6
`define SMET_SF_FRAMES 12
`define SMET_AXI_OKAY 2'h0
`define SMET_AXI_SLVERR 2'h2
`endif

// *** smet_far_model.sv ***
// Far side: highway source with frame sync, remote terminal looping the line
`default_nettype none
module smet_far_model (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic bit_stb_i,
    input wire logic line_tx_i,
    output logic highway_o,
    output logic highway_sync_o,
    output logic line_rx_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Loop delay of two superframes keeps frame, superframe and parity in step
    localparam logic [12:0] LOOP_BITS = 13'h1800;
    // Pin sync and sampling cost two bit times at two clocks a bit: read ahead
    localparam logic [12:0] LEAD = 13'h0002;
    logic [7:0] bit_cnt_r = 8'h00;
    logic [12:0] ptr_r = 13'h0000;
    logic [6143:0] loop_r = '1;
    logic [12:0] rd_ptr;
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bit_cnt_r <= 8'h00;
            ptr_r <= 13'h0000;
        end else if (bit_stb_i) begin
            bit_cnt_r <= bit_cnt_r + 8'h01;
            loop_r[ptr_r] <= line_tx_i;
            ptr_r <= (ptr_r == LOOP_BITS - 13'h0001) ? 13'h0000 : ptr_r + 13'h0001;
        end
    end
    assign rd_ptr = (ptr_r >= LOOP_BITS - LEAD) ? ptr_r - (LOOP_BITS - LEAD) : ptr_r + LEAD;
    // Zero every third bit of the count: two zeros meet only where 255 wraps to 0
    assign highway_o = (bit_cnt_r % 3) != 0;
    assign highway_sync_o = bit_cnt_r < 8'h08;
    assign line_rx_o = loop_r[rd_ptr];
endmodule // smet_far_model
`default_nettype wire

// *** smet_framer.v ***
// E1 time slot 0 framer, transparent modes and 16-state signaling map
// Overview of operation
// (R1) Loop-carrier superframe defaults to 16-state robbed-bit signaling; CTRL resets with the disable bit set, so signaling starts off.
// (R2) 16-state needs format bits 00, control bits 3,4 zero, disable bit 0.
// (R3) A and B go out as line A/B in one 12-frame superframe.
// (R4) Next superframe sends C as A-prime and D as B-prime, alternating.
// (R5) Receiver rebuilds A, B, C, D by the inverse mapping.
// (R6) E1 frame is 256 bits numbered 1..256 at 8 kHz.
// (R7) Alternate frames carry international bit then pattern 0011011 in slot 0.
// (R8) Non-alignment frames always send bit 2 as 1.
// (R9) Non-alignment bit 3 is remote alarm: 1 in alarm, else 0.
// (R10) Unused international bits should be 1 across borders.
// (R11) Unused spare bits 4..8 should be 1 across borders; the TS0 reset value 0x3F sends spare bit 4 as 0.
// (R12) Receiver does not modify CRC-4 bits after spare-bit changes.
// (R13) Bit 1 is MSB, sent first; bit 8 LSB, sent last.
// (R14) Transparent modes pass all 256 highway bits unmodified to line.
// (R15) Highway slot 1, found by frame sync, lands in line slot 0.
// (R16) Transparent modes keep frame position in transmit and receive.
// (R17) Mode 1 receiver never reframes, only monitors violations and AIS; the code monitors AIS only.
// (R18) Mode 2 receiver frames and monitors normally.
// (R19) Robbed bit replaces bit 8 of every voice channel each sixth frame.
// (R20) Signaling insertion and extraction only while disable bit is 0.
// (R21) One-bit superframe parity keeps A/B and C/D pairing aligned.
//
// Register access over AXI4-Lite and the address map were chosen for this implementation.
`default_nettype none
`include "smet_consts.vh"
module smet_framer #(
    parameter integer CLK_HZ = 250000000,
    parameter integer BIT_HZ = 2048000
) (
    // Clock and reset
    input wire REF_CLK_I,
    input wire NRST_I,
    // AXI4-Lite write address
    input wire [11:0] S_AXI_AWADDR_I,
    input wire S_AXI_AWVALID_I,
    output reg S_AXI_AWREADY_O,
    // AXI4-Lite write data
    input wire [31:0] S_AXI_WDATA_I,
    input wire [3:0] S_AXI_WSTRB_I,
    input wire S_AXI_WVALID_I,
    output reg S_AXI_WREADY_O,
    // AXI4-Lite write response
    output reg [1:0] S_AXI_BRESP_O,
    output reg S_AXI_BVALID_O,
    input wire S_AXI_BREADY_I,
    // AXI4-Lite read
    input wire [11:0] S_AXI_ARADDR_I,
    input wire S_AXI_ARVALID_I,
    output reg S_AXI_ARREADY_O,
    output reg [31:0] S_AXI_RDATA_O,
    output reg [1:0] S_AXI_RRESP_O,
    output reg S_AXI_RVALID_O,
    input wire S_AXI_RREADY_I,
    // System highway (bit serial, from pins)
    input wire SYS_HIGHWAY_I,
    input wire HIGHWAY_FRAME_SYNC_I,
    output reg RX_SYS_HIGHWAY_O,
    // Line (bit serial, from pins)
    input wire LINE_RX_I,
    output reg LINE_TX_O,
    output reg LINE_BIT_STB_O
);
    localparam [31:0] BIT_DIV = CLK_HZ / BIT_HZ;
    // Frame counter wraps at 256 bits, giving the 8 kHz frame rate
    localparam [7:0] LAST_BIT = 8'd255; // R6
    // Three-flop pin synchronisers
    reg [2:0] hw_s_r, fs_s_r, ln_s_r;
    reg hw_r, fs_r, ln_r;
    reg [31:0] div_r;
    reg [7:0] bit_r;
    reg fas_frame_r;
    reg [3:0] frm_r;
    reg sf_odd_r;
    reg fs_prev_r;
    reg [7:0] rx_sh_r;
    reg [31:0] ctrl_r, sigtx_r, ts0_r;
    reg [31:0] ais_cnt_r;
    reg ais_r, rx_fas_ok_r;
    // First line bit of the signaling pair, held from frame 6 to frame 12
    reg sig_first_r;
    wire stb = (div_r == BIT_DIV - 32'd1);
    wire [1:0] mode = ctrl_r[`SMET_CTRL_MODE_HI:`SMET_CTRL_MODE_LO];
    wire transp = (mode == `SMET_MODE_TR1) || (mode == `SMET_MODE_TR2);
    wire sig_en = !ctrl_r[`SMET_CTRL_SIGDIS] && !ctrl_r[`SMET_CTRL_LCS3] &&
        !ctrl_r[`SMET_CTRL_LCS4] &&
        (ctrl_r[`SMET_CTRL_FMT_HI:`SMET_CTRL_FMT_LO] == 2'b00); // R1 R2 R20
    wire [2:0] bit_in_ts = bit_r[2:0];
    wire in_ts0 = (bit_r[7:3] == 5'd0);
    // Signaling frame: 6th and 12th frame of the 12-frame superframe
    wire sig_frame = (frm_r == 4'd5) || (frm_r == 4'd11); // R19
    wire [1:0] sig_line;
    wire [3:0] rx_abcd;

    // Bit 1 of slot 0 first, MSB first in every slot
    function ts0_bit;
        input fas;
        input [2:0] idx;
        input [31:0] ts0;
        input rai;
        reg [7:0] w;
        begin
            if (fas) begin
                w = {ts0[0], `SMET_FAS_WORD}; // R7
            end else begin
                w = {ts0[1], 1'b1, rai, ts0[6:2]}; // R8 R9 R10 R11
            end
            ts0_bit = w[3'd7 - idx]; // R13
        end
    endfunction

    always @(posedge REF_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            hw_s_r <= 3'h0;
            fs_s_r <= 3'h0;
            ln_s_r <= 3'h0;
            hw_r <= 1'b0;
            fs_r <= 1'b0;
            ln_r <= 1'b0;
        end else begin
            hw_s_r <= {hw_s_r[1:0], SYS_HIGHWAY_I};
            fs_s_r <= {fs_s_r[1:0], HIGHWAY_FRAME_SYNC_I};
            ln_s_r <= {ln_s_r[1:0], LINE_RX_I};
            if (hw_s_r[1] == hw_s_r[2]) hw_r <= hw_s_r[2];
            if (fs_s_r[1] == fs_s_r[2]) fs_r <= fs_s_r[2];
            if (ln_s_r[1] == ln_s_r[2]) ln_r <= ln_s_r[2];
        end
    end

    // Bit timing and frame position
    always @(posedge REF_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            div_r <= 32'h0000_0000;
            bit_r <= 8'h00;
            fas_frame_r <= 1'b1;
            frm_r <= 4'h0;
            sf_odd_r <= 1'b0;
            fs_prev_r <= 1'b0;
            LINE_BIT_STB_O <= 1'b0;
        end else begin
            div_r <= stb ? 32'h0000_0000 : div_r + 32'd1;
            LINE_BIT_STB_O <= stb;
            if (stb) begin
                fs_prev_r <= fs_r;
                // Highway sync marks the start of its time slot 1
                if (transp && fs_r && !fs_prev_r) begin
                    bit_r <= 8'd0; // R15 R16
                end else if (bit_r == LAST_BIT) begin
                    bit_r <= 8'd0;
                    fas_frame_r <= !fas_frame_r; // R7
                    if (frm_r == 4'd11) begin
                        frm_r <= 4'd0;
                        sf_odd_r <= !sf_odd_r; // R21
                    end else begin
                        frm_r <= frm_r + 4'd1;
                    end
                end else begin
                    bit_r <= bit_r + 8'd1;
                end
            end
        end
    end

    smet_sig16 u_sig16 (
        .sf_odd_i(sf_odd_r),
        .en_i(sig_en),
        .tx_abcd_i(sigtx_r[3:0]),
        .tx_line_o(sig_line),
        .rx_line_i({sig_first_r, ln_r}),
        .rx_strobe_i(stb && frm_r == 4'd11 && bit_in_ts == 3'd7 && !in_ts0 && !transp),
        .clk_i(REF_CLK_I),
        .nrst_i(NRST_I),
        .rx_abcd_o(rx_abcd)
    );

    // Transmit and receive data paths
    always @(posedge REF_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            LINE_TX_O <= 1'b1;
            RX_SYS_HIGHWAY_O <= 1'b1;
            rx_sh_r <= 8'h00;
            rx_fas_ok_r <= 1'b0;
            sig_first_r <= 1'b1;
        end else if (stb) begin
            rx_sh_r <= {rx_sh_r[6:0], ln_r};
            if (sig_frame && !frm_r[3] && bit_in_ts == 3'd7 && !in_ts0)
                sig_first_r <= ln_r; // R5 R19
            if (transp) begin
                LINE_TX_O <= hw_r; // R14
            end else if (in_ts0) begin
                LINE_TX_O <= ts0_bit(fas_frame_r, bit_in_ts, ts0_r,
                    ctrl_r[`SMET_CTRL_RAI]);
            end else if (sig_en && sig_frame && bit_in_ts == 3'd7) begin
                // Alternate robbed bits carry the two line signaling bits
                LINE_TX_O <= frm_r[3] ? sig_line[0] : sig_line[1]; // R19 R3 R4
            end else begin
                LINE_TX_O <= hw_r;
            end
            // Mode 1 passes line payload untouched, no reframing
            RX_SYS_HIGHWAY_O <= ln_r; // R17 R18
            // Alignment word check only outside mode 1; CRC-4 bits never rewritten
            if (mode != `SMET_MODE_TR1 && in_ts0 && bit_in_ts == 3'd7 && fas_frame_r)
                rx_fas_ok_r <= ({rx_sh_r[5:0], ln_r} == `SMET_FAS_WORD); // R12 R18
        end
    end

    // Unframed AIS: a whole frame of ones; single-rail line has no violations to count
    always @(posedge REF_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            ais_cnt_r <= 32'h0000_0000;
            ais_r <= 1'b0;
        end else if (stb) begin
            if (!ln_r) begin
                ais_cnt_r <= 32'h0000_0000;
                ais_r <= 1'b0;
            end else if (ais_cnt_r == `SMET_FRAME_BITS - 1) begin
                ais_r <= 1'b1; // R17
            end else begin
                ais_cnt_r <= ais_cnt_r + 32'd1;
            end
        end
    end

    // AXI4-Lite slave, one write and one read in flight
    reg aw_got_r, w_got_r;
    reg [11:0] awaddr_r;
    reg [31:0] wdata_r;
    reg [3:0] wstrb_r;
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] be;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1)
                if (be[i]) merge[i*8 +: 8] = nw[i*8 +: 8];
        end
    endfunction
    always @(posedge REF_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            S_AXI_AWREADY_O <= 1'b1;
            S_AXI_WREADY_O <= 1'b1;
            S_AXI_BVALID_O <= 1'b0;
            S_AXI_BRESP_O <= `SMET_AXI_OKAY;
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awaddr_r <= 12'h000;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            ctrl_r <= `SMET_CTRL_RESET;
            sigtx_r <= 32'h0000_0000;
            ts0_r <= `SMET_TS0_RESET;
        end else begin
            if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
                awaddr_r <= S_AXI_AWADDR_I;
                aw_got_r <= 1'b1;
                S_AXI_AWREADY_O <= 1'b0;
            end
            if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
                wdata_r <= S_AXI_WDATA_I;
                wstrb_r <= S_AXI_WSTRB_I;
                w_got_r <= 1'b1;
                S_AXI_WREADY_O <= 1'b0;
            end
            if (aw_got_r && w_got_r && !S_AXI_BVALID_O) begin
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                S_AXI_BVALID_O <= 1'b1;
                S_AXI_BRESP_O <= `SMET_AXI_OKAY;
                case ({awaddr_r[11:2], 2'b00})
                    `SMET_REG_CTRL: ctrl_r <= merge(ctrl_r, wdata_r, wstrb_r) & 32'h0000_1379;
                    `SMET_REG_SIGTX: sigtx_r <= merge(sigtx_r, wdata_r, wstrb_r) & 32'h0000_000F;
                    `SMET_REG_TS0: ts0_r <= merge(ts0_r, wdata_r, wstrb_r) & 32'h0000_007F;
                    `SMET_REG_SIGRX, `SMET_REG_STAT: S_AXI_BRESP_O <= `SMET_AXI_OKAY;
                    default: S_AXI_BRESP_O <= `SMET_AXI_SLVERR;
                endcase
            end
            if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
                S_AXI_BVALID_O <= 1'b0;
                S_AXI_AWREADY_O <= 1'b1;
                S_AXI_WREADY_O <= 1'b1;
            end
        end
    end

    always @(posedge REF_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            S_AXI_ARREADY_O <= 1'b1;
            S_AXI_RVALID_O <= 1'b0;
            S_AXI_RDATA_O <= 32'h0000_0000;
            S_AXI_RRESP_O <= `SMET_AXI_OKAY;
        end else begin
            if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
                S_AXI_ARREADY_O <= 1'b0;
                S_AXI_RVALID_O <= 1'b1;
                S_AXI_RRESP_O <= `SMET_AXI_OKAY;
                case ({S_AXI_ARADDR_I[11:2], 2'b00})
                    `SMET_REG_CTRL: S_AXI_RDATA_O <= ctrl_r;
                    `SMET_REG_SIGTX: S_AXI_RDATA_O <= sigtx_r;
                    `SMET_REG_SIGRX: S_AXI_RDATA_O <= {28'h000_0000, rx_abcd};
                    `SMET_REG_STAT: S_AXI_RDATA_O <= {27'h000_0000, sig_en, sf_odd_r,
                        ais_r, rx_fas_ok_r, fas_frame_r};
                    `SMET_REG_TS0: S_AXI_RDATA_O <= ts0_r;
                    default: begin
                        S_AXI_RDATA_O <= 32'h0000_0000;
                        S_AXI_RRESP_O <= `SMET_AXI_SLVERR;
                    end
                endcase
            end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
                S_AXI_RVALID_O <= 1'b0;
                S_AXI_ARREADY_O <= 1'b1;
            end
        end
    end
endmodule // smet_framer
`default_nettype wire

// *** smet_framer_asserts.sv ***
// Bus handshake and line strobe checks for the framer
`default_nettype none
module smet_framer_asserts #(
    parameter integer CLK_HZ = 250000000,
    parameter integer BIT_HZ = 2048000
) (
    input wire logic REF_CLK_I,
    input wire logic NRST_I,
    input wire logic S_AXI_AWVALID_I,
    input wire logic S_AXI_AWREADY_O,
    input wire logic S_AXI_WVALID_I,
    input wire logic S_AXI_WREADY_O,
    input wire logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    input wire logic S_AXI_ARVALID_I,
    input wire logic S_AXI_ARREADY_O,
    input wire logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I,
    input wire logic LINE_BIT_STB_O
);
    timeunit 1ns;
    timeprecision 1ps;
    // Integer bit divider keeps every period at CLK_HZ / BIT_HZ cycles; the window allows one cycle either way
    localparam int PLO = CLK_HZ / BIT_HZ - 1;
    localparam int PHI = CLK_HZ / BIT_HZ + 1;
    default clocking @(posedge REF_CLK_I);
    endclocking
    default disable iff (!NRST_I);
    a_write_answer: assert property (S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I
        && S_AXI_WREADY_O |=> !S_AXI_AWREADY_O ##[1:2] S_AXI_BVALID_O)
        else $error("write response missing");
    a_read_answer: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O
        |=> S_AXI_RVALID_O && !S_AXI_ARREADY_O)
        else $error("read data missing");
    a_read_blocked: assert property (S_AXI_RVALID_O |-> !S_AXI_ARREADY_O)
        else $error("read address taken while data pending");
    a_write_blocked: assert property (S_AXI_BVALID_O |-> !S_AXI_AWREADY_O && !S_AXI_WREADY_O)
        else $error("write taken while response pending");
    a_bresp_released: assert property (S_AXI_BVALID_O && S_AXI_BREADY_I |=> !S_AXI_BVALID_O)
        else $error("write response not released");
    a_rdata_released: assert property (S_AXI_RVALID_O && S_AXI_RREADY_I |=> !S_AXI_RVALID_O)
        else $error("read data not released");
    a_strobe_pulse: assert property (LINE_BIT_STB_O |=> !LINE_BIT_STB_O)
        else $error("bit strobe too long");
    a_strobe_period: assert property (LINE_BIT_STB_O |-> ##[PLO:PHI] LINE_BIT_STB_O)
        else $error("bit strobe period wrong");
endmodule // smet_framer_asserts
bind smet_framer smet_framer_asserts #(.CLK_HZ(CLK_HZ), .BIT_HZ(BIT_HZ)) smet_framer_asserts_i (
    .REF_CLK_I(REF_CLK_I), .NRST_I(NRST_I),
    .S_AXI_AWVALID_I(S_AXI_AWVALID_I), .S_AXI_AWREADY_O(S_AXI_AWREADY_O),
    .S_AXI_WVALID_I(S_AXI_WVALID_I), .S_AXI_WREADY_O(S_AXI_WREADY_O),
    .S_AXI_BVALID_O(S_AXI_BVALID_O), .S_AXI_BREADY_I(S_AXI_BREADY_I),
    .S_AXI_ARVALID_I(S_AXI_ARVALID_I), .S_AXI_ARREADY_O(S_AXI_ARREADY_O),
    .S_AXI_RVALID_O(S_AXI_RVALID_O), .S_AXI_RREADY_I(S_AXI_RREADY_I),
    .LINE_BIT_STB_O(LINE_BIT_STB_O)
);
`default_nettype wire

// *** smet_framer_tb.sv ***
// Self-checking bench: registers, time slot 0, transparent modes, signaling
`default_nettype none
`include "smet_consts.vh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
    $display("wrong value at %0t: got %h want %h", $time, (g), (e)); end end
module smet_framer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [11:0] awaddr = 12'h000;
    logic [31:0] wdata = 32'h0000_0000;
    logic [11:0] araddr = 12'h000;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    wire logic awready, wready, bvalid, arready, rvalid, rx_hw, line_tx, stb, hw, hw_sync, line_rx;
    wire logic [1:0] bresp;
    wire logic [1:0] rresp;
    wire logic [31:0] rdata;
    logic [0:1039] cap_tx;
    logic [0:1039] cap_rx;
    int n_fail = 0;
    int tests_run = 0;
    // Fast bit clock (2 cycles a bit) keeps the superframes short
    smet_framer #(.BIT_HZ(125000000)) smet_framer_i (
        .REF_CLK_I(clk), .NRST_I(nrst),
        .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
        .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wvalid),
        .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
        .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
        .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
        .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
        .SYS_HIGHWAY_I(hw), .HIGHWAY_FRAME_SYNC_I(hw_sync), .RX_SYS_HIGHWAY_O(rx_hw),
        .LINE_RX_I(line_rx), .LINE_TX_O(line_tx), .LINE_BIT_STB_O(stb)
    );
    smet_far_model smet_far_model_i (
        .clk_i(clk), .nrst_i(nrst), .bit_stb_i(stb), .line_tx_i(line_tx),
        .highway_o(hw), .highway_sync_o(hw_sync), .line_rx_o(line_rx)
    );
    always #2 clk = ~clk;
    task automatic stop_test();
        if (n_fail == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic timeout();
        n_fail++;
        stop_test();
    endtask
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 50);
        if (n >= 50) timeout();
        `CHK(bresp, er)
        bready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic axi_rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] ed,
                          input logic [1:0] er);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 50);
        if (n >= 50) timeout();
        `CHK(rdata & m, ed)
        `CHK(rresp, er)
        rready <= 1'b0;
        @(posedge clk);
    endtask
    // Sample at the edge that sees the strobe; the bit was launched a cycle before
    task automatic capture();
        int w;
        repeat (2048) @(posedge clk);
        for (int n = 0; n < 1040; n++) begin
            w = 0;
            do begin
                @(posedge clk);
                w++;
            end while (stb !== 1'b1 && w < 20);
            if (w >= 20) timeout();
            cap_tx[n] = line_tx;
            cap_rx[n] = rx_hw;
        end
    endtask
    task automatic chk_stream(input logic [0:1039] c);
        int ones;
        int diffs;
        ones = 0;
        diffs = 0;
        for (int k = 0; k < 256; k++) ones += c[k];
        for (int k = 0; k < 768; k++) diffs += (c[k] !== c[k + 256]);
        `CHK(ones, 170)
        `CHK(diffs, 0)
    endtask
    task automatic find_ts0(input logic [15:0] e);
        int hit;
        hit = 0;
        for (int i = 0; i < 512; i++) begin
            if ({cap_tx[i +: 8], cap_tx[i + 256 +: 8]} === e
                && cap_tx[i + 512 +: 8] === e[15:8]) hit++;
        end
        `CHK(hit, 1)
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        timeout();
    end
    initial begin
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        axi_rd(`SMET_REG_CTRL, 32'hFFFF_FFFF, `SMET_CTRL_RESET, `SMET_AXI_OKAY);
        axi_rd(`SMET_REG_TS0, 32'hFFFF_FFFF, `SMET_TS0_RESET, `SMET_AXI_OKAY);
        axi_rd(12'h0FC, 32'hFFFF_FFFF, 32'h0000_0000, `SMET_AXI_SLVERR);
        axi_wr(12'h0FC, 32'h0000_0000, `SMET_AXI_SLVERR);
        // Each of disable, both control bits and both format bits blocks 16-state
        for (int i = 0; i < 6; i++) begin
            axi_wr(`SMET_REG_CTRL, (i == 0) ? 32'h0000_0000 : 32'h0000_0001 << ((i == 1) ? 0 : i + 1),
                   `SMET_AXI_OKAY);
            axi_rd(`SMET_REG_STAT, 32'h0000_0010, (i == 0) ? 32'h0000_0010 : 32'h0000_0000,
                   `SMET_AXI_OKAY);
        end
        axi_wr(`SMET_REG_TS0, 32'h0000_0056, `SMET_AXI_OKAY);
        axi_wr(`SMET_REG_CTRL, 32'h0000_1001, `SMET_AXI_OKAY);
        capture();
        find_ts0(16'h1BF5);
        for (int m = 1; m < 3; m++) begin
            axi_wr(`SMET_REG_CTRL, 32'h0000_0001 | (m << 8), `SMET_AXI_OKAY);
            // Let the looped line fill with transparent data first
            if (m == 1) repeat (12288) @(posedge clk);
            capture();
            chk_stream(cap_tx);
            if (m == 1) chk_stream(cap_rx);
            if (m == 1) axi_rd(`SMET_REG_STAT, 32'h0000_0004, 32'h0000_0000, `SMET_AXI_OKAY);
        end
        axi_wr(`SMET_REG_CTRL, 32'h0000_0000, `SMET_AXI_OKAY);
        // Pairs swapped between the two words, so a C/D mix-up shows
        for (int s = 0; s < 2; s++) begin
            axi_wr(`SMET_REG_SIGTX, s ? 32'h0000_0006 : 32'h0000_0009, `SMET_AXI_OKAY);
            // Both pairs sent and looped back within 54 frames
            repeat (60 * 512) @(posedge clk);
            axi_rd(`SMET_REG_SIGRX, 32'h0000_000F, s ? 32'h0000_0006 : 32'h0000_0009,
                   `SMET_AXI_OKAY);
        end
        stop_test();
    end
endmodule // smet_framer_tb
`default_nettype wire

// *** smet_sig16.v ***
// 16-state robbed-bit signaling map for a 12-frame superframe
`default_nettype none
module smet_sig16 (
    // Control
    input wire sf_odd_i,
    input wire en_i,
    // Transmit register bits A B C D
    input wire [3:0] tx_abcd_i,
    // Line bits
    output wire [1:0] tx_line_o,
    input wire [1:0] rx_line_i,
    input wire rx_strobe_i,
    input wire clk_i,
    input wire nrst_i,
    output reg [3:0] rx_abcd_o
);
    // Even superframe carries A,B; odd one carries C,D as A',B'
    assign tx_line_o = !en_i ? 2'b11 : (sf_odd_i ? tx_abcd_i[1:0] : tx_abcd_i[3:2]); // R3 R4
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rx_abcd_o <= 4'h0;
        end else if (en_i && rx_strobe_i) begin
            if (sf_odd_i) begin
                rx_abcd_o[1:0] <= rx_line_i; // R5
            end else begin
                rx_abcd_o[3:2] <= rx_line_i; // R5
            end
        end
    end
endmodule // smet_sig16
`default_nettype wire
